// ### design/vpf_consts.svh
// Constants of the video packet FIFO: register offsets, field positions, reset values.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef VPF_CONSTS_SVH
`define VPF_CONSTS_SVH

`define VPF_ADDR_THR_LO 8'h04
`define VPF_ADDR_ACT_THR_HI 8'h05
`define VPF_ADDR_LEN_LO 8'h06
`define VPF_ADDR_SPC_LEN_HI 8'h07

`define VPF_ACTIVE_BIT 7
`define VPF_THR_HI_MSB 2
`define VPF_SPC_MSB 7
`define VPF_SPC_LSB 2
`define VPF_LEN_HI_MSB 1

`define VPF_REG_RESET 8'h00
`define VPF_FIFO_DEPTH 2048
`define VPF_FIFO_AW 11
`define VPF_BUF_DEPTH 2

`endif

// ### design/vpf_pkg.sv
// Types shared by the video packet FIFO modules.
// Assumes the constants header is on the include path.
`include "vpf_consts.svh"

package vpf_pkg;

    // One stored byte, tagged when it is the first byte of a video frame.
    typedef struct packed {
        logic       sof;
        logic [7:0] data;
    } vpf_entry_t;

    typedef struct packed {
        logic [7:0] data;
        logic       last;
    } vpf_word_t;

    typedef struct packed {
        vpf_entry_t [`VPF_FIFO_DEPTH-1:0] mem;
        logic [`VPF_FIFO_AW-1:0] wr_ptr;
        logic [`VPF_FIFO_AW-1:0] rd_ptr;
        logic [`VPF_FIFO_AW:0] fill;
        logic [7:0] thr_lo;
        logic [7:0] act_thr_hi;
        logic [7:0] len_lo;
        logic [7:0] spc_len_hi;
        logic [5:0] spc_cnt;
        logic [9:0] pkt_cnt;
        logic [7:0] rdata;
        logic       vid_ready;
        logic [`VPF_FIFO_AW:0] fill_out;
    } vpf_main_t;

    typedef struct packed {
        vpf_word_t [`VPF_BUF_DEPTH-1:0] slot;
        logic [1:0] count;
    } vpf_buf_t;

endpackage

// ### design/vpf_stream_if.sv
// Byte stream carrier between the FIFO core and its output buffer.
// Assumes one clock shared by both ends.
`timescale 1ns/1ps

interface vpf_stream_if;
    logic [7:0] data;
    logic       last;
    logic       valid;
    logic       ready;

    modport src (output data, output last, output valid, input ready);
    modport dst (input data, input last, input valid, output ready);
endinterface

// ### design/vpf_out_buf.sv
// Two-entry output buffer between the FIFO read side and the USB packet port.
// Assumes a synchronous active-high reset; flush empties it in one cycle.
`timescale 1ns/1ps

module vpf_out_buf
    import vpf_pkg::*;
(
    input wire logic clk_i,    // System clock.
    input wire logic rst_i,    // Synchronous reset, active high.
    input wire logic flush_i,  // Empty the buffer.
    vpf_stream_if.dst in_s,    // Words from the FIFO core.
    vpf_stream_if.src out_s    // Words toward the USB channel.
);
    vpf_buf_t st;
    vpf_buf_t next_st;
    logic push;
    logic pop;

    assign in_s.ready = (st.count != 2'h2);
    assign out_s.valid = (st.count != 2'h0);
    assign out_s.data = st.slot[0].data;
    assign out_s.last = st.slot[0].last;
    assign push = in_s.valid && in_s.ready;
    assign pop = out_s.valid && out_s.ready;

    always_comb begin
        next_st = st;
        if (pop) begin
            next_st.slot[0] = st.slot[1];
        end
        if (push) begin
            next_st.slot[(pop ? st.count - 2'h1 : st.count) == 2'h0 ? 0 : 1] =
                '{data: in_s.data, last: in_s.last};
        end
        next_st.count = st.count + {1'b0, push} - {1'b0, pop};
        if (flush_i) begin
            next_st.count = 2'h0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end
endmodule

// ### design/vpf_fifo_top.sv
// Video packet FIFO: stores compressed frame bytes and releases them as USB packets.
// Assumes registers are written through the control-bus register port, one byte per strobe.
// Overview of operation
// - Frame-start threshold is eleven bits: low register plus bits 2..0 of 0x05.
// - A new frame that starts a USB packet leaves only after the fill level reaches the threshold; one starting mid-packet does not wait.
// - Bit 7 of 0x05 makes the FIFO operate when one.
// - Each USB packet carries the programmed packet length, 1 to 1023 bytes; a length of 0 stops reading.
// - Packet length is ten bits: low register plus bits 1..0 of 0x07.
// - Bits 7..2 of 0x07 set the read pulse period, 1 to 63.
// - The four setting registers sit at byte addresses 0x04 to 0x07.
`timescale 1ns/1ps
`include "vpf_consts.svh"

module vpf_fifo_top
    import vpf_pkg::*;
(
    input wire logic CLK_I,           // System clock, 125 MHz.
    input wire logic RST_I,           // Synchronous reset, active high.
    input wire logic REG_WR_I,        // Register write strobe.
    input wire logic [7:0] REG_ADDR_I, // Register byte address.
    input wire logic [7:0] REG_WDATA_I, // Register write data.
    output logic [7:0] REG_RDATA_O,   // Register read data, one cycle late.
    input wire logic [7:0] VID_DATA_I, // Compressed video byte.
    input wire logic VID_SOF_I,       // Byte is the first of a frame.
    input wire logic VID_VALID_I,     // Video byte offered.
    output logic VID_READY_O,         // FIFO takes the video byte.
    output logic [7:0] USB_DATA_O,    // Packet byte.
    output logic USB_LAST_O,          // Last byte of a packet.
    output logic USB_VALID_O,         // Packet byte offered.
    input wire logic USB_READY_I,     // USB side takes the byte.
    output logic [11:0] FILL_LEVEL_O  // Bytes held in the FIFO.
);
    vpf_main_t st;
    vpf_main_t next_st;
    vpf_stream_if core_s ();
    vpf_stream_if usb_s ();

    logic active;
    logic [10:0] threshold;
    logic [9:0] pkt_len;
    logic [5:0] spacing;
    logic read_pulse;
    logic head_ok;
    logic do_read;
    logic do_write;
    vpf_entry_t head;

    assign threshold = {st.act_thr_hi[`VPF_THR_HI_MSB:0], st.thr_lo};
    assign pkt_len = {st.spc_len_hi[`VPF_LEN_HI_MSB:0], st.len_lo};
    assign spacing = st.spc_len_hi[`VPF_SPC_MSB:`VPF_SPC_LSB];
    assign active = st.act_thr_hi[`VPF_ACTIVE_BIT];

    assign head = st.mem[st.rd_ptr];
    assign read_pulse = (spacing != 6'h00) && (st.spc_cnt >= spacing - 6'h01);
    assign head_ok = !head.sof || (st.pkt_cnt != 10'h000) ||
        ({1'b0, threshold} <= st.fill);
    assign do_read = active && read_pulse && (st.fill != '0) && head_ok &&
        (pkt_len != 10'h000) && core_s.ready;
    assign do_write = VID_VALID_I && st.vid_ready;

    assign core_s.valid = do_read;
    assign core_s.data = head.data;
    assign core_s.last = (st.pkt_cnt == pkt_len - 10'h001);

    always_comb begin
        next_st = st;
        if (REG_WR_I) begin
            unique case (REG_ADDR_I)
                `VPF_ADDR_THR_LO: next_st.thr_lo = REG_WDATA_I;
                `VPF_ADDR_ACT_THR_HI: next_st.act_thr_hi =
                    REG_WDATA_I & 8'h87;
                `VPF_ADDR_LEN_LO: next_st.len_lo = REG_WDATA_I;
                `VPF_ADDR_SPC_LEN_HI: next_st.spc_len_hi = REG_WDATA_I;
                default: next_st.thr_lo = st.thr_lo;
            endcase
        end
        unique case (REG_ADDR_I)
            `VPF_ADDR_THR_LO: next_st.rdata = st.thr_lo;
            `VPF_ADDR_ACT_THR_HI: next_st.rdata = st.act_thr_hi;
            `VPF_ADDR_LEN_LO: next_st.rdata = st.len_lo;
            `VPF_ADDR_SPC_LEN_HI: next_st.rdata = st.spc_len_hi;
            default: next_st.rdata = 8'h00;
        endcase

        if (!active || read_pulse) begin
            next_st.spc_cnt = 6'h00;
        end else begin
            next_st.spc_cnt = st.spc_cnt + 6'h01;
        end

        if (do_write) begin
            next_st.mem[st.wr_ptr] = '{sof: VID_SOF_I, data: VID_DATA_I};
            next_st.wr_ptr = st.wr_ptr + 11'h001;
        end
        if (do_read) begin
            next_st.rd_ptr = st.rd_ptr + 11'h001;
            next_st.pkt_cnt = core_s.last ? 10'h000 : st.pkt_cnt + 10'h001;
        end
        next_st.fill = st.fill + {11'h000, do_write} - {11'h000, do_read};

        if (!active) begin
            next_st.wr_ptr = '0;
            next_st.rd_ptr = '0;
            next_st.fill = '0;
            next_st.pkt_cnt = 10'h000;
        end
        // The ready is a flop, so one slot is kept spare for the byte in flight.
        next_st.vid_ready = (next_st.fill[10:0] != 11'h7ff) && !next_st.fill[11] &&
            next_st.act_thr_hi[`VPF_ACTIVE_BIT] && !(do_write && !do_read &&
            next_st.fill == 12'h7fe);
        next_st.fill_out = next_st.fill;
    end

    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    vpf_out_buf u_buf (
        .clk_i(CLK_I),
        .rst_i(RST_I),
        .flush_i(!active),
        .in_s(core_s.dst),
        .out_s(usb_s.src)
    );

    assign usb_s.ready = USB_READY_I;
    assign USB_DATA_O = usb_s.data;
    assign USB_LAST_O = usb_s.last;
    assign USB_VALID_O = usb_s.valid;
    assign REG_RDATA_O = st.rdata;
    assign VID_READY_O = st.vid_ready;
    assign FILL_LEVEL_O = st.fill_out;
endmodule

// ### verification/vpf_sva.sv
// Port checker of the video packet FIFO top.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
module vpf_sva (
    input wire logic CLK_I, // Clock.
    input wire logic RST_I, // Reset.
    input wire logic REG_WR_I, // Write strobe.
    input wire logic [7:0] REG_ADDR_I, // Address.
    input wire logic [7:0] REG_WDATA_I, // Write data.
    input wire logic [7:0] REG_RDATA_O, // Read data.
    input wire logic VID_READY_O, // Input ready.
    input wire logic [7:0] USB_DATA_O, // Packet byte.
    input wire logic USB_LAST_O, // Packet end.
    input wire logic USB_VALID_O, // Byte offered.
    input wire logic USB_READY_I, // Byte taken.
    input wire logic [11:0] FILL_LEVEL_O // Fill.
);
    logic [7:0] mir [0:3];
    logic [9:0] cnt;
    logic [7:0] exp_rd;
    wire act = mir[1][7];
    default clocking @(posedge CLK_I); endclocking
    default disable iff (RST_I);
    always_comb exp_rd = (REG_ADDR_I[7:2] == 6'h01) ? mir[REG_ADDR_I[1:0]] : 8'h00;
    // Mirror reads reserved bits of the active register as zero.
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            mir <= '{default: 8'h00};
            cnt <= 10'h000;
        end else begin
            if (REG_WR_I && REG_ADDR_I[7:2] == 6'h01)
                mir[REG_ADDR_I[1:0]] <= REG_WDATA_I & ((REG_ADDR_I[1:0] == 2'h1) ? 8'h87 : 8'hff);
            if (!act)
                cnt <= 10'h000;
            else if (USB_VALID_O && USB_READY_I)
                cnt <= USB_LAST_O ? 10'h000 : cnt + 10'h001;
        end
    end
    sequence s_go;
        !act && REG_WR_I && REG_ADDR_I == 8'h05 && REG_WDATA_I[7];
    endsequence
    go_ready_a: assert property (s_go |-> ##2 VID_READY_O)
        else $error("input ready did not rise after activation");
    // An activating write lifts ready at the same edge that updates the mirror.
    idle_ready_a: assert property (!act && !(REG_WR_I && REG_ADDR_I == 8'h05 &&
        REG_WDATA_I[7]) |=> !VID_READY_O)
        else $error("input ready while inactive");
    idle_usb_a: assert property (!act [*2] |=> !USB_VALID_O)
        else $error("packet byte while inactive");
    idle_fill_a: assert property (!act [*2] |=> FILL_LEVEL_O == 12'h000)
        else $error("fill not empty while inactive");
    read_back_a: assert property (REG_RDATA_O == $past(exp_rd))
        else $error("register read value wrong");
    res_zero_a: assert property ($past(REG_ADDR_I) == 8'h05 |-> REG_RDATA_O[6:3] == 4'h0)
        else $error("reserved bits read nonzero");
    hold_usb_a: assert property (act && !REG_WR_I && USB_VALID_O && !USB_READY_I
        |=> USB_VALID_O && $stable(USB_DATA_O) && $stable(USB_LAST_O))
        else $error("stalled packet byte changed");
    last_pos_a: assert property (act && USB_VALID_O
        |-> USB_LAST_O == (cnt == {mir[3][1:0], mir[2]} - 10'h001))
        else $error("packet end at wrong byte");
endmodule
bind vpf_fifo_top vpf_sva u_sva (.*);

// ### verification/vpf_usb_sink.sv
// USB sink model: takes packet bytes, checks their order, measures spacing.
// Assumes the bench raises stall_i to withhold ready.
`timescale 1ns/1ps
module vpf_usb_sink (
    input wire logic clk_i, // Clock.
    input wire logic rst_i, // Reset.
    input wire logic stall_i, // Withhold ready.
    input wire logic [7:0] data_i, // Byte.
    input wire logic last_i, // Packet end.
    input wire logic valid_i, // Byte offered.
    output logic ready_o, // Byte taken.
    output int got_o, // Bytes taken.
    output int last_o, // Packet ends.
    output int bad_o, // Bytes out of order.
    output int gap_o // Shortest spacing.
);
    int since;
    always @(posedge clk_i) begin
        if (rst_i) begin
            ready_o <= 1'b0;
            {got_o, last_o, bad_o} <= '0;
            gap_o <= 999;
            since <= 999;
        end else begin
            ready_o <= !stall_i;
            since <= since + 1;
            if (valid_i && ready_o) begin
                bad_o <= bad_o + int'(data_i !== got_o[7:0]);
                got_o <= got_o + 1;
                last_o <= last_o + int'(last_i);
                since <= 1;
                gap_o <= (since < gap_o) ? since : gap_o;
            end
        end
    end
endmodule

// ### verification/testbench.sv
// Self-checking bench of the video packet FIFO.
// Assumes a 125 MHz clock and the sink model on the packet port.
`timescale 1ns/1ps
module testbench;
    logic clk = 1'b0, rst = 1'b1, wr = 1'b0, sof = 1'b0, vv = 1'b0, stall = 1'b0;
    logic [7:0] adr = 8'h00, wd = 8'h00, vd = 8'h00, rd, ud;
    logic vr, ul, uv, ur;
    logic [11:0] fill;
    int n_mismatch = 0, n_tests = 0, seq = 0, got, lst, bad, gap;
    always #4 clk = ~clk;
    vpf_fifo_top i_dut (.CLK_I(clk), .RST_I(rst), .REG_WR_I(wr), .REG_ADDR_I(adr),
        .REG_WDATA_I(wd), .REG_RDATA_O(rd), .VID_DATA_I(vd), .VID_SOF_I(sof),
        .VID_VALID_I(vv), .VID_READY_O(vr), .USB_DATA_O(ud), .USB_LAST_O(ul),
        .USB_VALID_O(uv), .USB_READY_I(ur), .FILL_LEVEL_O(fill));
    vpf_usb_sink i_sink (.clk_i(clk), .rst_i(rst), .stall_i(stall), .data_i(ud), .last_i(ul),
        .valid_i(uv), .ready_o(ur), .got_o(got), .last_o(lst), .bad_o(bad), .gap_o(gap));
    task automatic chk(input string what, input logic [11:0] e, input logic [11:0] g);
        n_tests++;
        if (g !== e) begin
            n_mismatch++;
            $display("unexpected %s: expected %h, seen %h", what, e, g);
        end
    endtask
    task automatic wrr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        wr <= 1'b1;
        adr <= a;
        wd <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        adr <= a;
        @(posedge clk);
        #1 chk("register read", {4'h0, e}, {4'h0, rd});
    endtask
    task automatic push(input int n);
        for (int i = 0; i < n; i++) begin
            vv <= 1'b1;
            vd <= seq[7:0];
            sof <= (seq == 0);
            do @(posedge clk); while (vr !== 1'b1);
            seq++;
        end
        vv <= 1'b0;
    endtask
    task automatic wait_got(input int n);
        for (int i = 0; i < 3000 && got < n; i++) @(posedge clk);
    endtask
    task automatic report_and_stop;
        $display("comparisons %0d, mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        for (int a = 4; a < 9; a++) rdc(8'(a), 8'h00);
        wrr(8'h05, 8'h7f);
        rdc(8'h05, 8'h07);
        wrr(8'h08, 8'hff);
        rdc(8'h08, 8'h00);
        wrr(8'h04, 8'h0a);
        wrr(8'h06, 8'h04);
        wrr(8'h07, 8'h0d);
        rdc(8'h07, 8'h0d);
        wrr(8'h05, 8'h81);
        $display("register test done");
        // Threshold is 0x10a, packet length 0x104, read spacing 3.
        push(265);
        repeat (20) @(posedge clk);
        chk("bytes below threshold", 12'd0, got[11:0]);
        chk("fill level", 12'd265, fill);
        push(1);
        wait_got(266);
        chk("bytes out", 12'd266, got[11:0]);
        chk("packet ends", 12'd1, lst[11:0]);
        chk("read spacing", 12'd3, gap[11:0]);
        $display("threshold test done");
        stall <= 1'b1;
        push(20);
        repeat (100) @(posedge clk);
        chk("bytes while stalled", 12'd266, got[11:0]);
        chk("fill while stalled", 12'd18, fill);
        stall <= 1'b0;
        wait_got(286);
        chk("bytes after stall", 12'd286, got[11:0]);
        chk("order errors", 12'd0, bad[11:0]);
        $display("stall test done");
        stall <= 1'b1;
        push(5);
        wrr(8'h05, 8'h01);
        repeat (4) @(posedge clk);
        chk("fill when inactive", 12'd0, fill);
        chk("input ready", 12'd0, {11'h0, vr});
        chk("packet valid", 12'd0, {11'h0, uv});
        $display("inactive test done");
        report_and_stop;
    end
    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        report_and_stop;
    end
endmodule
